// file: hdl/pwc_ctrl.sv
// Chip power mode controller: mode sequencing, power controls and APB registers
//
// Function
// - Run, wait and stop modes; each run variant has its own wait and stop.
// - Core wait-for-interrupt instruction starts every wait or stop entry.
// - Reset leaves normal run with regulator fully on.
// - Normal wait sleeps core, peripherals clocked, any interrupt returns to run.
// - Normal stop keeps state and voltage detect, stops clocks, async wake recovers.
// - Very low power wait is that run with core asleep, fast clock on.
// - Very low power stop static, fast clock off, async wake recovers, SRAM kept.
// - Low leakage stop keeps state; only wake unit and enabled NMI or reset pin wake.
// - Low leakage stop recovery resumes run without reset, unless an enabled reset pin wakes it, which resets.
// - Leak stop three keeps both SRAM halves; wake comes through reset.
// - Leak stops one and zero power SRAM off; reset recovery only.
// - Leak stop zero disables low power oscillator; brown-out detect optional.
// - Leak stop recovery resets but keeps the leakage wake flag raised.
// - Pin states are held stable in every wait and stop mode.
// - Leakage modes wake only from wake unit, NMI pin, reset pin, if enabled.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwc_params.svh"
module pwc_ctrl (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [7:0]             paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   wfi_req,
    input  wire logic                   sleep_deep,
    input  wire pwc_pkg::pwc_wake_src_t wake_src,
    input  wire logic                   pwm_src_on,
    input  wire logic                   uart_src_on,
    output pwc_pkg::pwc_pwr_t           pwr,
    output logic [3:0]                  mode,
    output logic                        io_hold,
    output logic                        wake_reset_req,
    output logic                        leak_irq_flag,
    output logic                        irq
);
    import pwc_pkg::*;

    pwc_state_t                 state_reg;
    pwc_state_t                 state_next;
    pwc_wake_t                  wake;
    pwc_pwr_t                   pwr_reg;
    pwc_pwr_t                   pwr_next;
    logic [`PWC_CTRL_W-1:0]     ctrl_reg;
    logic [`PWC_IRQ_W-1:0]      irq_stat_reg;
    logic [`PWC_IRQ_W-1:0]      irq_mask_reg;
    logic [`PWC_IRQ_W-1:0]      irq_set;
    logic [31:0]                prdata_reg;
    logic [3:0]                 mode_reg;
    logic                       hold_latch_reg;
    logic                       io_hold_reg;
    logic                       flag_reg;
    logic                       wreset_reg;
    logic                       irq_reg;
    logic                       in_run;
    logic                       bad_tgt;
    logic                       setup;
    logic                       wr_acc;
    logic                       mapped;
    logic [2:0]                 tgt;

    // Stop state chosen for a deep sleep; illegal target codes give run
    function automatic pwc_state_t pick_stop(input logic [2:0] t, input logic vlp);
        pwc_state_t s;
        s = ST_RUN;
        unique case (t)
            `PWC_TGT_STOP:   s = vlp ? ST_VSTOP : ST_STOP;
            `PWC_TGT_VSTOP:  s = ST_VSTOP;
            `PWC_TGT_LLSTOP: s = ST_LLSTOP;
            `PWC_TGT_LEAK3:  s = ST_LEAK3;
            `PWC_TGT_LEAK1:  s = ST_LEAK1;
            `PWC_TGT_LEAK0:  s = ST_LEAK0;
            default:         s = ST_RUN;
        endcase
        return s;
    endfunction : pick_stop

    // Numeric mode code for software and the outside world
    function automatic logic [3:0] mode_of(input pwc_state_t s);
        logic [3:0] m;
        m = 4'h0;
        unique case (s)
            ST_RUN:    m = 4'h0;
            ST_VRUN:   m = 4'h1;
            ST_WAIT:   m = 4'h2;
            ST_VWAIT:  m = 4'h3;
            ST_STOP:   m = 4'h4;
            ST_VSTOP:  m = 4'h5;
            ST_LLSTOP: m = 4'h6;
            ST_LEAK3:  m = 4'h7;
            ST_LEAK1:  m = 4'h8;
            ST_LEAK0:  m = 4'h9;
        endcase
        return m;
    endfunction : mode_of

    // Wake source qualification lives in its own small block
    pwc_wake_qual u_wake (
        .state   (state_reg),
        .src     (wake_src),
        .nmi_en  (ctrl_reg[`PWC_CTRL_NMI_EN]),
        .rpin_en (ctrl_reg[`PWC_CTRL_RPIN_EN]),
        .wake    (wake)
    );

    assign in_run  = (state_reg == ST_RUN) || (state_reg == ST_VRUN);
    assign tgt     = ctrl_reg[`PWC_CTRL_TGT_HI:`PWC_CTRL_TGT_LO];
    assign bad_tgt = in_run && wfi_req && sleep_deep && (pick_stop(tgt, 1'b0) == ST_RUN);

    // Next mode: sleep entry, wake exit and run-variant switching
    always_comb
    begin
        state_next = state_reg;
        if (in_run && wfi_req)
        begin
            if (!sleep_deep)
                state_next = (state_reg == ST_VRUN) ? ST_VWAIT : ST_WAIT;
            else if (!bad_tgt)
                state_next = pick_stop(tgt, state_reg == ST_VRUN);
        end
        else if (in_run)
        begin
            // Variant changes only between sleeps, never mid-entry
            state_next = ctrl_reg[`PWC_CTRL_VLP] ? ST_VRUN : ST_RUN;
        end
        else if (wake == WK_RESET)
            state_next = ST_RUN;
        else if (wake == WK_RESUME)
            state_next = (state_reg == ST_VWAIT || state_reg == ST_VSTOP) ? ST_VRUN : ST_RUN;
    end

    // Mode state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= ST_RUN;
        else
            state_reg <= state_next;
    end

    // Power and clock controls for the mode being entered
    always_comb
    begin
        pwr_next = pwc_pwr_t'(`PWC_PWR_RST);
        unique case (state_next)
            ST_RUN:
                pwr_next = pwc_pwr_t'(`PWC_PWR_RST);
            ST_VRUN, ST_VWAIT:
            begin
                pwr_next.reg_lowpower  = 1'b1;
                pwr_next.flash_lowfreq = 1'b1;
                pwr_next.vdet_en       = 1'b0;
                pwr_next.core_clk_en   = (state_next == ST_VRUN);
            end
            ST_WAIT:
                pwr_next.core_clk_en = 1'b0;
            ST_STOP, ST_VSTOP:
            begin
                pwr_next.core_clk_en   = 1'b0;
                pwr_next.fast_clk_en   = 1'b0;
                pwr_next.periph_clk_en = 1'b0;
                pwr_next.intc_en       = 1'b0;
                pwr_next.awuc_en       = 1'b1;
                pwr_next.pwm_clk_en    = 1'b0;
                pwr_next.uart_clk_en   = 1'b0;
                if (state_next == ST_VSTOP)
                begin
                    pwr_next.reg_lowpower = 1'b1;
                    pwr_next.vdet_en      = 1'b0;
                    pwr_next.pwm_clk_en   = ctrl_reg[`PWC_CTRL_PWM_KEEP] & pwm_src_on;
                    pwr_next.uart_clk_en  = ctrl_reg[`PWC_CTRL_UART_KEEP] & uart_src_on;
                end
            end
            ST_LLSTOP, ST_LEAK3, ST_LEAK1, ST_LEAK0:
            begin
                pwr_next.core_clk_en   = 1'b0;
                pwr_next.fast_clk_en   = 1'b0;
                pwr_next.periph_clk_en = 1'b0;
                pwr_next.intc_en       = 1'b0;
                pwr_next.lwku_en       = 1'b1;
                pwr_next.reg_lowpower  = 1'b1;
                pwr_next.vdet_en       = 1'b0;
                pwr_next.pwm_clk_en    = 1'b0;
                pwr_next.uart_clk_en   = 1'b0;
                if (state_next == ST_LEAK1 || state_next == ST_LEAK0)
                begin
                    pwr_next.reg_lowpower  = 1'b0;
                    pwr_next.reg_off       = 1'b1;
                    pwr_next.sram_upper_on = 1'b0;
                    pwr_next.sram_lower_on = 1'b0;
                end
                if (state_next == ST_LEAK0)
                begin
                    pwr_next.losc_en     = 1'b0;
                    pwr_next.brownout_en = ctrl_reg[`PWC_CTRL_BO_EN];
                end
            end
        endcase
    end

    // Controls leave flip-flops so no glitch reaches the analog parts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pwr_reg <= pwc_pwr_t'(`PWC_PWR_RST);
        else
            pwr_reg <= pwr_next;
    end

    // Mode code output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_reg <= 4'h0;
        else
            mode_reg <= mode_of(state_next);
    end

    // After a leak stop reset the pins stay held until software releases them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_latch_reg <= 1'b0;
        else if (wake == WK_RESET)
            hold_latch_reg <= 1'b1;
        else if (wr_acc && paddr == `PWC_OFF_RELEASE && pwdata[`PWC_REL_IO])
            hold_latch_reg <= 1'b0;
    end

    // Pins held in every mode other than run, and while the latch stands
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            io_hold_reg <= 1'b0;
        else
            io_hold_reg <= (state_next != ST_RUN && state_next != ST_VRUN)
                           || hold_latch_reg || (wake == WK_RESET);
    end

    // Leak wake flag toward the interrupt controller; a new wake beats a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_reg <= 1'b0;
        else if (wake != WK_NONE && state_reg != ST_WAIT && state_reg != ST_VWAIT
                 && state_reg != ST_STOP && state_reg != ST_VSTOP)
            flag_reg <= 1'b1;
        else if (wr_acc && paddr == `PWC_OFF_RELEASE && pwdata[`PWC_REL_FLAG])
            flag_reg <= 1'b0;
    end

    // One-cycle request for the chip reset flow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wreset_reg <= 1'b0;
        else
            wreset_reg <= (wake == WK_RESET);
    end

    // APB decode: zero wait states, error on unmapped offsets
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign mapped = (paddr == `PWC_OFF_CTRL) || (paddr == `PWC_OFF_STAT)
                    || (paddr == `PWC_OFF_IRQ_STAT) || (paddr == `PWC_OFF_IRQ_MASK)
                    || (paddr == `PWC_OFF_RELEASE);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= `PWC_CTRL_RST;
        else if (wr_acc && paddr == `PWC_OFF_CTRL)
            ctrl_reg <= pwdata[`PWC_CTRL_W-1:0];
    end

    // Interrupt mask register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= `PWC_IRQ_RST;
        else if (wr_acc && paddr == `PWC_OFF_IRQ_MASK)
            irq_mask_reg <= pwdata[`PWC_IRQ_W-1:0];
    end

    // Events: resume wake, reset wake, refused deep sleep target
    always_comb
    begin
        irq_set                  = '0;
        irq_set[`PWC_IRQ_RESUME] = (wake == WK_RESUME);
        irq_set[`PWC_IRQ_RESET]  = (wake == WK_RESET);
        irq_set[`PWC_IRQ_BADTGT] = bad_tgt;
    end

    // Sticky status, write one to clear; a set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_reg <= `PWC_IRQ_RST;
        else if (wr_acc && paddr == `PWC_OFF_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~pwdata[`PWC_IRQ_W-1:0]) | irq_set;
        else
            irq_stat_reg <= irq_stat_reg | irq_set;
    end

    // Level interrupt output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= |((irq_stat_reg | irq_set) & irq_mask_reg);
    end

    // Read data captured in the setup cycle, valid through the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            unique case (paddr)
                `PWC_OFF_CTRL:     prdata_reg <= {23'h000000, ctrl_reg};
                `PWC_OFF_STAT:     prdata_reg <= {25'h0000000, flag_reg, io_hold_reg,
                                                  pwr_reg.core_clk_en, mode_reg};
                `PWC_OFF_IRQ_STAT: prdata_reg <= {29'h00000000, irq_stat_reg};
                `PWC_OFF_IRQ_MASK: prdata_reg <= {29'h00000000, irq_mask_reg};
                default:           prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Output drive; the flag must stay unmasked by software to exit cleanly
    assign prdata         = prdata_reg;
    assign pwr            = pwr_reg;
    assign mode           = mode_reg;
    assign io_hold        = io_hold_reg;
    assign wake_reset_req = wreset_reg;
    assign leak_irq_flag  = flag_reg;
    assign irq            = irq_reg;
endmodule : pwc_ctrl
`default_nettype wire

// file: hdl/pwc_params.svh
// Register map, field positions, reset values and encodings of the power mode controller
`ifndef PWC_PARAMS_SVH
`define PWC_PARAMS_SVH
`define PWC_OFF_CTRL      8'h00
`define PWC_OFF_STAT      8'h04
`define PWC_OFF_IRQ_STAT  8'h08
`define PWC_OFF_IRQ_MASK  8'h0C
`define PWC_OFF_RELEASE   8'h10
`define PWC_CTRL_W        9
`define PWC_CTRL_RST      9'h070
`define PWC_CTRL_TGT_HI   2
`define PWC_CTRL_TGT_LO   0
`define PWC_CTRL_VLP      3
`define PWC_CTRL_NMI_EN   4
`define PWC_CTRL_RPIN_EN  5
`define PWC_CTRL_BO_EN    6
`define PWC_CTRL_PWM_KEEP 7
`define PWC_CTRL_UART_KEEP 8
`define PWC_TGT_STOP      3'h0
`define PWC_TGT_VSTOP     3'h1
`define PWC_TGT_LLSTOP    3'h2
`define PWC_TGT_LEAK3     3'h3
`define PWC_TGT_LEAK1     3'h4
`define PWC_TGT_LEAK0     3'h5
`define PWC_IRQ_W         3
`define PWC_IRQ_RESUME    0
`define PWC_IRQ_RESET     1
`define PWC_IRQ_BADTGT    2
`define PWC_IRQ_RST       3'h0
`define PWC_REL_IO        0
`define PWC_REL_FLAG      1
`define PWC_PWR_RST       16'hE33F
`endif

// file: hdl/pwc_pkg.sv
// Types shared by the power mode controller files
package pwc_pkg;
    typedef enum logic [9:0] {
        ST_RUN    = 10'h001,
        ST_VRUN   = 10'h002,
        ST_WAIT   = 10'h004,
        ST_VWAIT  = 10'h008,
        ST_STOP   = 10'h010,
        ST_VSTOP  = 10'h020,
        ST_LLSTOP = 10'h040,
        ST_LEAK3  = 10'h080,
        ST_LEAK1  = 10'h100,
        ST_LEAK0  = 10'h200
    } pwc_state_t;
    typedef enum logic [1:0] {
        WK_NONE   = 2'h0,
        WK_RESUME = 2'h1,
        WK_RESET  = 2'h2
    } pwc_wake_t;
    typedef struct packed {
        logic irq_pending;
        logic async_wake;
        logic leak_wake;
        logic nmi_pin;
        logic reset_pin;
    } pwc_wake_src_t;
    typedef struct packed {
        logic core_clk_en;
        logic fast_clk_en;
        logic periph_clk_en;
        logic flash_lowfreq;
        logic reg_lowpower;
        logic reg_off;
        logic vdet_en;
        logic intc_en;
        logic awuc_en;
        logic lwku_en;
        logic sram_upper_on;
        logic sram_lower_on;
        logic losc_en;
        logic brownout_en;
        logic pwm_clk_en;
        logic uart_clk_en;
    } pwc_pwr_t;
endpackage : pwc_pkg

// file: hdl/pwc_wake_qual.sv
// Wake source qualification for each power state
`timescale 1ns/1ps
`default_nettype none
module pwc_wake_qual (
    input  wire pwc_pkg::pwc_state_t    state,
    input  wire pwc_pkg::pwc_wake_src_t src,
    input  wire logic                   nmi_en,
    input  wire logic                   rpin_en,
    output pwc_pkg::pwc_wake_t          wake
);
    import pwc_pkg::*;

    logic leak_src;
    logic pin_rst;

    // Disabled pins are simply not wake sources in leakage modes
    assign leak_src = src.leak_wake | (src.nmi_pin & nmi_en);
    assign pin_rst  = src.reset_pin & rpin_en;

    // Per-state wake decision
    always_comb
    begin
        wake = WK_NONE;
        unique case (state)
            ST_RUN, ST_VRUN:
                wake = WK_NONE;
            ST_WAIT, ST_VWAIT:
            begin
                if (src.irq_pending)
                    wake = WK_RESUME;
            end
            ST_STOP, ST_VSTOP:
            begin
                if (src.async_wake)
                    wake = WK_RESUME;
            end
            ST_LLSTOP:
            begin
                if (pin_rst)
                    wake = WK_RESET;
                else if (leak_src)
                    wake = WK_RESUME;
            end
            ST_LEAK3, ST_LEAK1, ST_LEAK0:
            begin
                if (leak_src | pin_rst)
                    wake = WK_RESET;
            end
        endcase
    end
endmodule : pwc_wake_qual
`default_nettype wire

// file: tb/pwc_core_model.sv
// Core side model: turns a sleep command into a one-cycle wait-for-interrupt pulse
`timescale 1ns/1ps
`default_nettype none
module pwc_core_model (
    input  wire logic pclk,
    output var logic  wfi_req,
    output var logic  sleep_deep
);
    initial
    begin
        wfi_req    = 1'b0;
        sleep_deep = 1'b0;
    end

    // Sleep-deep is only qualified by the pulse, so it flips afterwards to catch late sampling
    task automatic sleep(input logic deep);
        @(posedge pclk);
        wfi_req    <= 1'b1;
        sleep_deep <= deep;
        @(posedge pclk);
        wfi_req    <= 1'b0;
        sleep_deep <= ~deep;
    endtask : sleep
endmodule : pwc_core_model
`default_nettype wire

// file: tb/pwc_ctrl_properties.sv
// Timing and power state checks at the controller ports
`timescale 1ns/1ps
`default_nettype none
module pwc_ctrl_properties (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic [3:0]             mode,
    input wire logic                   wfi_req,
    input wire logic                   sleep_deep,
    input wire pwc_pkg::pwc_wake_src_t wake_src,
    input wire pwc_pkg::pwc_pwr_t      pwr,
    input wire logic                   io_hold,
    input wire logic                   wake_reset_req,
    input wire logic                   leak_irq_flag
);
    import pwc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Reset wake: one-cycle request with the flag raised
    sequence s_reset_wake;
        wake_reset_req && leak_irq_flag && mode == 4'h0 ##1 !wake_reset_req;
    endsequence
    property p_run_reg;
        mode == 4'h0 |-> !pwr.reg_lowpower && !pwr.reg_off;
    endproperty
    property p_wfi_wait;
        (mode == 4'h0 || mode == 4'h1) && wfi_req && !sleep_deep |=> mode == $past(mode) + 4'h2;
    endproperty
    property p_wait_pwr;
        mode == 4'h2 |-> pwr.periph_clk_en && pwr.intc_en && !pwr.core_clk_en;
    endproperty
    property p_wait_wake;
        mode == 4'h2 && wake_src.irq_pending |=> mode == 4'h0;
    endproperty
    property p_stop_pwr;
        mode == 4'h4 |-> pwr.vdet_en && !pwr.periph_clk_en && !pwr.intc_en && pwr.awuc_en;
    endproperty
    property p_vlp_pwr;
        mode == 4'h1 || mode == 4'h3 |-> pwr.flash_lowfreq && pwr.reg_lowpower && !pwr.vdet_en;
    endproperty
    property p_vstop_pwr;
        mode == 4'h5 |-> !pwr.fast_clk_en && !pwr.intc_en && pwr.awuc_en && pwr.sram_upper_on && pwr.sram_lower_on;
    endproperty
    property p_sram_off;
        mode == 4'h8 || mode == 4'h9 |-> !pwr.sram_upper_on && !pwr.sram_lower_on && pwr.lwku_en;
    endproperty
    property p_losc_off;
        mode == 4'h9 |-> !pwr.losc_en;
    endproperty
    property p_leak_wake;
        mode >= 4'h7 && wake_src.leak_wake |=> s_reset_wake;
    endproperty
    property p_ll_resume;
        mode == 4'h6 && wake_src.leak_wake && !wake_src.reset_pin |=> mode == 4'h0 && !wake_reset_req && leak_irq_flag;
    endproperty
    property p_leak_quiet;
        mode >= 4'h6 && wake_src == '0 |=> $stable(mode);
    endproperty
    property p_io_hold;
        mode >= 4'h2 |-> io_hold;
    endproperty

    a_run_reg:    assert property (p_run_reg) else $error("regulator not fully on in run");
    a_wfi_wait:   assert property (p_wfi_wait) else $error("shallow sleep did not enter wait");
    a_wait_pwr:   assert property (p_wait_pwr) else $error("wait power state wrong");
    a_wait_wake:  assert property (p_wait_wake) else $error("interrupt did not end wait");
    a_stop_pwr:   assert property (p_stop_pwr) else $error("stop power state wrong");
    a_vlp_pwr:    assert property (p_vlp_pwr) else $error("low power run state wrong");
    a_vstop_pwr:  assert property (p_vstop_pwr) else $error("low power stop state wrong");
    a_sram_off:   assert property (p_sram_off) else $error("sram not off in deep leak stop");
    a_losc_off:   assert property (p_losc_off) else $error("oscillator on in leak stop zero");
    a_leak_wake:  assert property (p_leak_wake) else $error("leak stop wake not via reset");
    a_ll_resume:  assert property (p_ll_resume) else $error("low leak resume wrong");
    a_leak_quiet: assert property (p_leak_quiet) else $error("leak mode left without source");
    a_io_hold:    assert property (p_io_hold) else $error("pins not held in sleep");
endmodule : pwc_ctrl_properties

bind pwc_ctrl pwc_ctrl_properties u_props (.pclk(pclk), .presetn(presetn), .mode(mode), .wfi_req(wfi_req),
    .sleep_deep(sleep_deep), .wake_src(wake_src), .pwr(pwr), .io_hold(io_hold),
    .wake_reset_req(wake_reset_req), .leak_irq_flag(leak_irq_flag));
`default_nettype wire

// file: tb/pwc_ctrl_bench.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pwc_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
module pwc_ctrl_bench;
    import pwc_pkg::*;
    typedef struct packed {
        logic [8:0]    ctrl;
        logic          deep;
        pwc_wake_src_t w;
        logic [1:0]    src;
        logic [3:0]    ms;
        logic [3:0]    mw;
        logic [2:0]    st;
    } pwc_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, err, wfi_req, sleep_deep, pwm_src_on = 1'b1, uart_src_on = 1'b1;
    logic io_hold, wake_reset_req, leak_irq_flag, irq;
    logic [3:0] mode;
    pwc_wake_src_t wake_src = '0;
    pwc_pwr_t pwr;
    pwc_row_t r;
    int miscompares = 0, check_count = 0;
    // Sleep target, wake source and the modes and status they should give
    pwc_row_t rows [12] = '{
        '{9'h070, 1'b0, 5'h10, 2'h3, 4'h2, 4'h0, 3'h1}, '{9'h070, 1'b1, 5'h08, 2'h3, 4'h4, 4'h0, 3'h1},
        '{9'h071, 1'b1, 5'h08, 2'h3, 4'h5, 4'h1, 3'h1}, '{9'h1F1, 1'b1, 5'h08, 2'h2, 4'h5, 4'h1, 3'h1},
        '{9'h072, 1'b1, 5'h04, 2'h3, 4'h6, 4'h0, 3'h1}, '{9'h062, 1'b1, 5'h02, 2'h3, 4'h6, 4'h6, 3'h0},
        '{9'h072, 1'b1, 5'h01, 2'h3, 4'h6, 4'h0, 3'h2}, '{9'h073, 1'b1, 5'h04, 2'h3, 4'h7, 4'h0, 3'h2},
        '{9'h074, 1'b1, 5'h02, 2'h3, 4'h8, 4'h0, 3'h2}, '{9'h075, 1'b1, 5'h04, 2'h3, 4'h9, 4'h0, 3'h2},
        '{9'h078, 1'b0, 5'h10, 2'h3, 4'h3, 4'h1, 3'h1}, '{9'h078, 1'b1, 5'h08, 2'h3, 4'h5, 4'h1, 3'h1}};

    always #2.5 pclk = ~pclk;

    pwc_core_model core (.pclk(pclk), .wfi_req(wfi_req), .sleep_deep(sleep_deep));

    pwc_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wfi_req(wfi_req), .sleep_deep(sleep_deep), .wake_src(wake_src), .pwm_src_on(pwm_src_on),
        .uart_src_on(uart_src_on), .pwr(pwr), .mode(mode), .io_hold(io_hold),
        .wake_reset_req(wake_reset_req), .leak_irq_flag(leak_irq_flag), .irq(irq));

    // One APB transfer; read data and error are taken at the edge that completes it
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_reset();
        @(negedge pclk);
        `CHK("mode_rst", 4'h0, mode)
        `CHK("pwr_rst", 16'hE33F, pwr)
        apb(`PWC_OFF_CTRL, 1'b0, 32'h0);
        `CHK("ctrl_rst", 32'h70, rdata)
    endtask : chk_reset

    task automatic stop_test();
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    // Watchdog sized well past the expected few hundred cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk_reset();
        apb(`PWC_OFF_IRQ_MASK, 1'b1, 32'h7);
        foreach (rows[i])
        begin
            r = rows[i];
            apb(`PWC_OFF_CTRL, 1'b1, {23'h0, r.ctrl});
            {pwm_src_on, uart_src_on} <= r.src;
            core.sleep(r.deep);
            @(negedge pclk);
            `CHK("mode_sleep", r.ms, mode)
            if (r.ms == 4'h5)
                `CHK("keep_clk", {r.src[1] & r.ctrl[7], r.src[0] & r.ctrl[8]}, {pwr.pwm_clk_en, pwr.uart_clk_en})
            @(posedge pclk);
            wake_src <= r.w;
            @(posedge pclk);
            wake_src <= '0;
            @(negedge pclk);
            `CHK("mode_wake", r.mw, mode)
            `CHK("reset_req", r.st == 3'h2, wake_reset_req)
            `CHK("leak_flag", r.ms >= 4'h6 && r.mw != r.ms, leak_irq_flag)
            apb(`PWC_OFF_IRQ_STAT, 1'b0, 32'h0);
            `CHK("wake_stat", r.st, rdata[2:0])
            `CHK("wake_irq", r.st != 3'h0, irq)
            `CHK("io_held", r.st == 3'h2 || r.mw >= 4'h2, io_hold)
            wake_src <= 5'h04;
            @(posedge pclk);
            wake_src <= '0;
            apb(`PWC_OFF_RELEASE, 1'b1, 32'h3);
            apb(`PWC_OFF_IRQ_STAT, 1'b1, 32'h7);
            @(negedge pclk);
            `CHK("io_free", 1'b0, io_hold)
        end
        // Unmapped address answers with an error and zero data
        apb(8'h20, 1'b0, 32'h0);
        `CHK("bad_addr_err", 1'b1, err)
        `CHK("bad_addr_data", 32'h0, rdata)
        // Illegal target keeps run and raises a maskable event
        apb(`PWC_OFF_IRQ_MASK, 1'b1, 32'h0);
        apb(`PWC_OFF_CTRL, 1'b1, 32'h76);
        core.sleep(1'b1);
        repeat (2) @(negedge pclk);
        `CHK("bad_tgt_mode", 4'h0, mode)
        `CHK("irq_masked", 1'b0, irq)
        apb(`PWC_OFF_IRQ_MASK, 1'b1, 32'h4);
        repeat (2) @(negedge pclk);
        `CHK("irq_raised", 1'b1, irq)
        apb(`PWC_OFF_IRQ_STAT, 1'b1, 32'h4);
        repeat (2) @(negedge pclk);
        `CHK("irq_cleared", 1'b0, irq)
        // A second request while asleep is ignored, then reset in mid-sleep
        apb(`PWC_OFF_CTRL, 1'b1, 32'h70);
        core.sleep(1'b0);
        core.sleep(1'b1);
        @(negedge pclk);
        `CHK("wfi_ignored", 4'h2, mode)
        // Status word in wait: mode 2, core clock off, pins held, no leak flag
        apb(`PWC_OFF_STAT, 1'b0, 32'h0);
        `CHK("stat_wait", 32'h22, rdata)
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_reset();
        stop_test();
    end
endmodule : pwc_ctrl_bench
`default_nettype wire
